// ---- rtl/rss_defs.svh ----
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// register indices (byte address = 4 * index)
`define RSS_IDX_STAT1 8'h35
`define RSS_IDX_STAT2 8'h55
`define RSS_IDX_SW1 8'h34
`define RSS_IDX_SW2 8'h54
`define RSS_IDX_IMASK 8'h70
`define RSS_IDX_ISTAT 8'h71

// switch mode fields
`define RSS_SW_STOP_L 0
`define RSS_SW_STOP_R 1
`define RSS_SW_POL_L 2
`define RSS_SW_WIDTH 3
`define RSS_SW_RESET 3'h0

// status fields
`define RSS_ST_STOP_L 0
`define RSS_ST_STOP_R 1
`define RSS_ST_EV_POS 7
`define RSS_ST_VEL_REACHED 8
`define RSS_ST_POS_REACHED 9
`define RSS_ST_VZERO 10
`define RSS_ST_ZWAIT 11
`define RSS_ST_SECOND 12
`define RSS_ST_STALL 13
`define RSS_ST_WIDTH 14

// interrupt status bits
`define RSS_IRQ_POS1 0
`define RSS_IRQ_POS2 1
`define RSS_IRQ_REV1 2
`define RSS_IRQ_REV2 3
`define RSS_IRQ_WIDTH 4
`define RSS_IMASK_RESET 4'hF

`endif

// ---- rtl/rss_pkg.sv ----
package rss_pkg;

  typedef struct packed {
    logic [31:0] actual_position;
    logic [31:0] target_position;
    logic [31:0] actual_velocity;
    logic [31:0] max_velocity;
    logic stall_detect;
    logic reverse_needed;
    logic zero_wait_active;
  } rss_ramp_t;

  typedef struct packed {
    logic left_limit_input;
    logic right_limit_input;
  } rss_limits_t;

  typedef enum logic [1:0] {
    RSS_RUN,
    RSS_HALT_L,
    RSS_HALT_R
  } rss_halt_state_t;

endpackage

// ---- rtl/rss_clr_flag.sv ----
`timescale 1ns/100ps
// clear-on-read sticky flag; a set in the clearing cycle wins
module rss_clr_flag
(
  input wire logic clk,
  input wire logic reset,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag
);

  logic flag_nxt;

  assign flag_nxt = set_in | (flag & ~clear_in); // RQ17

  always_ff @(posedge clk)
  begin
    if (reset)
      flag <= 1'b0;
    else
      flag <= flag_nxt;
  end

endmodule

// ---- rtl/rss_axis.sv ----
`timescale 1ns/100ps
`include "rss_defs.svh"
// one axis: switch stop control and status word
module rss_axis
  import rss_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [`RSS_SW_WIDTH-1:0] sw_mode,
  input wire rss_limits_t limits,
  input wire rss_ramp_t ramp,
  input wire logic stat_read,
  output logic [`RSS_ST_WIDTH-1:0] status,
  output logic halt,
  output logic pos_event,
  output logic rev_event
);

  logic left_active;
  logic right_active;
  logic vel_neg;
  logic vel_pos;
  logic halt_l;
  logic halt_r;
  logic pos_match;
  logic pos_match_r;
  logic pos_rise;
  logic rev_r;
  logic ev_pos;
  logic ev_rev;
  rss_halt_state_t state_r;
  rss_halt_state_t state_nxt;

  // polarity 1 means low level stops
  assign left_active = limits.left_limit_input ^ sw_mode[`RSS_SW_POL_L]; // RQ1
  // right switch has no polarity bit anywhere, high active
  assign right_active = limits.right_limit_input;
  assign vel_neg = ramp.actual_velocity[31];
  assign vel_pos = ~ramp.actual_velocity[31] & (|ramp.actual_velocity);
  // stop only toward the active switch
  assign halt_l = sw_mode[`RSS_SW_STOP_L] & left_active & vel_neg; // RQ3 RQ15
  assign halt_r = sw_mode[`RSS_SW_STOP_R] & right_active & vel_pos; // RQ2 RQ15
  assign pos_match = ramp.actual_position == ramp.target_position; // RQ10
  assign pos_rise = pos_match & ~pos_match_r; // RQ12
  assign pos_event = pos_rise;
  assign rev_event = ramp.reverse_needed & ~rev_r;

  // =========================================
  // halt state
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      RSS_RUN:
        if (halt_l)
          state_nxt = RSS_HALT_L;
        else if (halt_r)
          state_nxt = RSS_HALT_R;
      // held until the switch releases, its enable drops or the move turns away;
      // zero velocity keeps the halt, as the ramp decays to rest while stopped
      RSS_HALT_L:
        if (!(left_active & sw_mode[`RSS_SW_STOP_L]) | vel_pos)
          state_nxt = RSS_RUN; // RQ4 RQ15
      RSS_HALT_R:
        if (!(right_active & sw_mode[`RSS_SW_STOP_R]) | vel_neg)
          state_nxt = RSS_RUN; // RQ4 RQ15
      default:
        state_nxt = RSS_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_r <= RSS_RUN;
      pos_match_r <= 1'b0;
      rev_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      pos_match_r <= pos_match;
      rev_r <= ramp.reverse_needed;
    end
  end

  assign halt = (state_r != RSS_RUN);

  rss_clr_flag u_pos
  (
    .clk(clk),
    .reset(reset),
    .set_in(pos_rise),
    .clear_in(stat_read),
    .flag(ev_pos)
  );

  rss_clr_flag u_rev
  (
    .clk(clk),
    .reset(reset),
    .set_in(ramp.reverse_needed), // RQ7
    .clear_in(stat_read),
    .flag(ev_rev)
  );

  // =========================================
  // status word
  always_comb
  begin
    status = '0;
    status[`RSS_ST_STOP_L] = left_active; // RQ16
    status[`RSS_ST_STOP_R] = right_active; // RQ16
    status[`RSS_ST_EV_POS] = ev_pos; // RQ12
    status[`RSS_ST_VEL_REACHED] = ramp.actual_velocity == ramp.max_velocity; // RQ11
    status[`RSS_ST_POS_REACHED] = pos_match; // RQ10
    status[`RSS_ST_VZERO] = ~(|ramp.actual_velocity); // RQ9
    status[`RSS_ST_ZWAIT] = ramp.zero_wait_active; // RQ8
    status[`RSS_ST_SECOND] = ev_rev; // RQ7
    status[`RSS_ST_STALL] = ramp.stall_detect; // RQ5
  end

endmodule

// ---- rtl/rss_top.sv ----
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`include "rss_defs.svh"
// Notes on behaviour
// RQ1: left polarity bit 2: 0 high level stops, 1 low level stops.
// RQ2: right stop enable bit 1 halts motor while right switch active.
// RQ3: left stop enable bit 0 halts motor while left switch active.
// RQ4: motion resumes by itself once the stopping switch releases.
// RQ5: status bit 13 shows live stall detect input.
// RQ6: host should enable stall halt, since polling may miss stalls; this design has no stall halt, stall only shows in status bit 13.
// RQ7: status bit 12 flags reverse move needed, cleared by status read.
// RQ8: status bit 11 high during standstill wait after stop.
// RQ9: status bit 10 high when actual velocity is zero.
// RQ10: status bit 9 high while actual equals target position.
// RQ11: status bit 8 high while actual velocity equals max velocity.
// RQ12: status bit 7 set on position match rise, cleared by read.
// RQ13: position event flag drives the interrupt output.
// RQ14: status registers at index 0x35 and 0x55.
// RQ15: left stop needs negative velocity, right stop positive velocity.
// RQ16: status bits 0 and 1 show left and right switch active.
// RQ17: event in the clearing read cycle keeps the flag set.
module rss_top
  import rss_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic irq,
  input wire rss_limits_t limits1,
  input wire rss_limits_t limits2,
  input wire rss_ramp_t ramp1,
  input wire rss_ramp_t ramp2,
  output logic halt1,
  output logic halt2
);

  // =========================================
  // address decode
  logic [7:0] idx;
  logic word_ok;
  logic sel_stat1;
  logic sel_stat2;
  logic sel_sw1;
  logic sel_sw2;
  logic sel_imask;
  logic sel_istat;

  assign idx = addr[9:2];
  assign word_ok = addr[1:0] == 2'h0;
  assign sel_stat1 = word_ok & (idx == `RSS_IDX_STAT1); // RQ14
  assign sel_stat2 = word_ok & (idx == `RSS_IDX_STAT2); // RQ14
  assign sel_sw1 = word_ok & (idx == `RSS_IDX_SW1);
  assign sel_sw2 = word_ok & (idx == `RSS_IDX_SW2);
  assign sel_imask = word_ok & (idx == `RSS_IDX_IMASK);
  assign sel_istat = word_ok & (idx == `RSS_IDX_ISTAT);

  // =========================================
  // control registers
  logic [`RSS_SW_WIDTH-1:0] sw1_r;
  logic [`RSS_SW_WIDTH-1:0] sw2_r;
  logic [`RSS_IRQ_WIDTH-1:0] imask_r;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sw1_r <= `RSS_SW_RESET;
      sw2_r <= `RSS_SW_RESET;
      imask_r <= `RSS_IMASK_RESET;
    end
    else if (wr)
    begin
      if (sel_sw1)
        sw1_r <= wdata[`RSS_SW_WIDTH-1:0];
      if (sel_sw2)
        sw2_r <= wdata[`RSS_SW_WIDTH-1:0];
      if (sel_imask)
        imask_r <= wdata[`RSS_IRQ_WIDTH-1:0];
    end
  end

  // =========================================
  // axes
  logic [`RSS_ST_WIDTH-1:0] stat1;
  logic [`RSS_ST_WIDTH-1:0] stat2;
  logic h1;
  logic h2;
  logic pos_ev1;
  logic pos_ev2;
  logic rev_ev1;
  logic rev_ev2;
  logic rd_stat1;
  logic rd_stat2;

  assign rd_stat1 = rd & sel_stat1;
  assign rd_stat2 = rd & sel_stat2;

  rss_axis u_axis1
  (
    .clk(clk),
    .reset(reset),
    .sw_mode(sw1_r),
    .limits(limits1),
    .ramp(ramp1),
    .stat_read(rd_stat1),
    .status(stat1),
    .halt(h1),
    .pos_event(pos_ev1),
    .rev_event(rev_ev1)
  );

  rss_axis u_axis2
  (
    .clk(clk),
    .reset(reset),
    .sw_mode(sw2_r),
    .limits(limits2),
    .ramp(ramp2),
    .stat_read(rd_stat2),
    .status(stat2),
    .halt(h2),
    .pos_event(pos_ev2),
    .rev_event(rev_ev2)
  );

  // =========================================
  // interrupt status, cleared by its own read
  logic [`RSS_IRQ_WIDTH-1:0] istat_r;
  logic [`RSS_IRQ_WIDTH-1:0] istat_set;
  logic [`RSS_IRQ_WIDTH-1:0] istat_nxt;
  logic rd_istat;
  logic irq_nxt;

  assign rd_istat = rd & sel_istat;
  assign istat_set = {rev_ev2, rev_ev1, pos_ev2, pos_ev1};
  // set beats the clearing read
  assign istat_nxt = istat_set | (istat_r & {`RSS_IRQ_WIDTH{~rd_istat}}); // RQ17
  // position flags in the status words also raise the line directly
  assign irq_nxt = (|(istat_nxt & imask_r))
    | (imask_r[`RSS_IRQ_POS1] & (stat1[`RSS_ST_EV_POS] & ~rd_stat1 | pos_ev1))
    | (imask_r[`RSS_IRQ_POS2] & (stat2[`RSS_ST_EV_POS] & ~rd_stat2 | pos_ev2)); // RQ13

  // =========================================
  // read data, one cycle after the strobe
  logic [31:0] rdata_nxt;

  assign rdata_nxt = !rd ? 32'h0 :
    sel_stat1 ? {18'h0, stat1} :
    sel_stat2 ? {18'h0, stat2} :
    sel_sw1 ? {29'h0, sw1_r} :
    sel_sw2 ? {29'h0, sw2_r} :
    sel_imask ? {28'h0, imask_r} :
    sel_istat ? {28'h0, istat_r} :
    32'h0;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      istat_r <= '0;
      rdata <= 32'h0;
      irq <= 1'b0;
      halt1 <= 1'b0;
      halt2 <= 1'b0;
    end
    else
    begin
      istat_r <= istat_nxt;
      rdata <= rdata_nxt;
      irq <= irq_nxt;
      halt1 <= h1;
      halt2 <= h2;
    end
  end

endmodule

// ---- dv/rss_props.sv ----
`timescale 1ns/100ps
module rss_props
  import rss_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic irq,
  input wire rss_limits_t limits1,
  input wire rss_limits_t limits2,
  input wire rss_ramp_t ramp1,
  input wire rss_ramp_t ramp2,
  input wire logic halt1,
  input wire logic halt2
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ==========
  // helpers
  wire m1 = ramp1.actual_position == ramp1.target_position;
  wire c1 = ramp1.actual_velocity[31] || (ramp1.actual_velocity != 32'h0 && limits1.right_limit_input);
  wire c2 = ramp2.actual_velocity[31] || (ramp2.actual_velocity != 32'h0 && limits2.right_limit_input);
  wire [4:0] l1 = {ramp1.stall_detect, ramp1.zero_wait_active, ramp1.actual_velocity == 32'h0, m1,
    ramp1.actual_velocity == ramp1.max_velocity};
  wire [4:0] l2 = {ramp2.stall_detect, ramp2.zero_wait_active, ramp2.actual_velocity == 32'h0,
    ramp2.actual_position == ramp2.target_position, ramp2.actual_velocity == ramp2.max_velocity};
  // ==========
  // assertions
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
  unmapped_rd_a: assert property (rd && (addr == 10'h3FC || addr == 10'h0D5) |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  live_bits1_a: assert property (rd && addr == 10'h0D4 && $stable(ramp1) && !$past(reset)
    |=> {rdata[13], rdata[11:8]} == $past(l1)) else $error("axis1 live bits wrong");
  live_bits2_a: assert property (rd && addr == 10'h154 && $stable(ramp2) && !$past(reset)
    |=> {rdata[13], rdata[11:8]} == $past(l2)) else $error("axis2 live bits wrong");
  right_seen_a: assert property (rd && addr == 10'h0D4 && $stable(limits1) && !$past(reset)
    |=> rdata[1] == $past(limits1.right_limit_input)) else $error("right switch bit wrong");
  halt_dir1_a: assert property (halt1 |-> $past(c1) || $past(c1, 2)) else $error("axis1 halt wrong way");
  halt_dir2_a: assert property (halt2 |-> $past(c2) || $past(c2, 2)) else $error("axis2 halt wrong way");
  event_clear_a: assert property ((rd && addr == 10'h0D4 && $stable(m1)) ##1 $stable(m1)
    ##1 (rd && addr == 10'h0D4 && $stable(m1)) |=> !rdata[7]) else $error("event flag not cleared");
  cover property ($rose(halt1));
  cover property ($rose(irq));
  cover property ($rose(m1));
endmodule

bind rss_top rss_props rss_props_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .irq(irq), .limits1(limits1), .limits2(limits2), .ramp1(ramp1), .ramp2(ramp2),
  .halt1(halt1), .halt2(halt2));

// ---- dv/rss_mech.sv ----
`timescale 1ns/100ps
// ramp generator and switches of one axis; lvl = stall, reverse, wait, left, right
module rss_mech
  import rss_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic halt,
  input wire logic [31:0] vel,
  input wire logic [31:0] tgt,
  input wire logic [4:0] lvl,
  output rss_ramp_t ramp,
  output rss_limits_t limits
);
  logic [31:0] pos_r;
  // one step a cycle in the direction of vel's sign until pos equals target; a halt freezes it
  always_ff @(posedge clk)
    if (reset)
      pos_r <= 32'h0;
    else if (!halt && pos_r != tgt)
      pos_r <= vel[31] ? pos_r - 32'h1 : pos_r + 32'h1;
  assign ramp = '{pos_r, tgt, vel, 32'h0, lvl[4], lvl[3], lvl[2]};
  assign limits = '{lvl[1], lvl[0]};
endmodule

// ---- dv/rss_top_tb_top.sv ----
`timescale 1ns/100ps
module rss_top_tb_top;
  import rss_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] addr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic irq;
  logic halt1;
  logic halt2;
  rss_limits_t limits1;
  rss_limits_t limits2;
  rss_ramp_t ramp1;
  rss_ramp_t ramp2;
  logic [31:0] vel1 = 32'h0;
  logic [31:0] tgt1 = 32'h0;
  logic [31:0] vel2 = 32'h0;
  logic [4:0] lvl1 = 5'h0;
  logic [4:0] lvl2 = 5'h0;
  logic [31:0] mk [2] = '{32'h0, 32'hF};
  int n_mismatch = 0;
  int checks = 0;
  always #2 clk = ~clk;
  rss_top rss_top_inst (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .irq(irq), .limits1(limits1), .limits2(limits2), .ramp1(ramp1), .ramp2(ramp2), .halt1(halt1), .halt2(halt2));
  rss_mech rss_mech_inst (.clk(clk), .reset(reset), .halt(halt1), .vel(vel1), .tgt(tgt1), .lvl(lvl1),
    .ramp(ramp1), .limits(limits1));
  rss_mech rss_mech2_inst (.clk(clk), .reset(reset), .halt(halt2), .vel(vel2), .tgt(32'h0), .lvl(lvl2),
    .ramp(ramp2), .limits(limits2));
  // ==========
  // tasks
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    chk(what, v, e);
    @(posedge clk);
  endtask
  task automatic wait_halt(input logic e);
    for (int i = 0; i < 20 && halt1 !== e; i++)
      @(posedge clk);
    chk("halt1", {31'h0, halt1}, {31'h0, e});
  endtask
  task automatic end_sim;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    end_sim;
  end
  // ==========
  // tests
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rchk("sw1", 10'h0D0, 32'h0);
    rchk("imask", 10'h1C0, 32'hF);
    rchk("unmapped", 10'h3FC, 32'h0);
    rchk("misaligned", 10'h0D5, 32'h0);
    lvl1 <= 5'h14;
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rchk("stat1", 10'h0D4, 32'h2F80);
    rchk("stat1", 10'h0D4, 32'h2F00);
    rchk("stat2", 10'h154, 32'h0780);
    rchk("istat", 10'h1C4, 32'h3);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test status done");
    foreach (mk[i])
    begin
      wr_reg(10'h1C0, mk[i]);
      lvl1 <= 5'h18;
      @(posedge clk);
      lvl1 <= 5'h10;
      repeat (3) @(posedge clk);
      chk("irq", {31'h0, irq}, {31'h0, mk[i][2]});
      wr_reg(10'h0D4, 32'h3FFF);
      rchk("stat1", 10'h0D4, 32'h3700);
      rchk("stat1", 10'h0D4, 32'h2700);
      rchk("istat", 10'h1C4, 32'h4);
    end
    $display("test reverse done");
    lvl1 <= 5'h01;
    vel1 <= 32'h1;
    tgt1 <= 32'h64;
    wr_reg(10'h0D0, 32'h2);
    wait_halt(1'b1);
    rchk("stat1", 10'h0D4, 32'h2);
    vel1 <= 32'hFFFFFFFF;
    wait_halt(1'b0);
    vel1 <= 32'h1;
    wait_halt(1'b1);
    lvl1 <= 5'h00;
    wait_halt(1'b0);
    vel1 <= 32'hFFFFFFFF;
    wr_reg(10'h0D0, 32'h5);
    wait_halt(1'b1);
    rchk("stat1", 10'h0D4, 32'h1);
    lvl1 <= 5'h02;
    wait_halt(1'b0);
    wr_reg(10'h0D0, 32'h1);
    wait_halt(1'b1);
    wr_reg(10'h0D0, 32'h0);
    wait_halt(1'b0);
    lvl2 <= 5'h01;
    vel2 <= 32'h1;
    wr_reg(10'h150, 32'h2);
    repeat (3) @(posedge clk);
    chk("halt2", {31'h0, halt2}, 32'h1);
    wr_reg(10'h150, 32'h0);
    $display("test switch done");
    vel1 <= 32'h1;
    tgt1 <= ramp1.actual_position + 32'h4;
    for (int i = 0; i < 20 && irq !== 1'b1; i++)
      @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rchk("stat1", 10'h0D4, 32'h0281);
    rchk("istat", 10'h1C4, 32'h1);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test position done");
    end_sim;
  end
endmodule
